// ==== design/scmc_pkg.sv ====
// Shared constants and types for the system clock and mode controller
package scmc_pkg;

   // ==========================================================
   // Selection codes
   localparam logic [2:0] SEL_FAST_DIV1 = 3'h0; // Fast clock undivided
   localparam logic [2:0] SEL_SUB = 3'h7; // Sub clock as system clock
   localparam int DIV_STAGES = 7; // Taps for ratios 1,2,4..64

   // ==========================================================
   // Oscillator pin indices
   localparam int OSC_EXT_FAST = 0;
   localparam int OSC_INT_FAST = 1;
   localparam int OSC_EXT_SLOW = 2;
   localparam int OSC_INT_SLOW = 3;
   localparam int OSC_NUM = 4;

   // ==========================================================
   // Switch timing: current system clock periods before a change
   localparam int SWITCH_PERIODS = 4;
   localparam int SW_CNT_W = 3;

   // ==========================================================
   // Operating modes, one-hot
   typedef enum logic [5:0] {
      MODE_FAST = 6'h01,
      MODE_SLOW = 6'h02,
      MODE_SLEEP = 6'h04,
      MODE_IDLE_SLOW_ONLY = 6'h08,
      MODE_IDLE_BOTH = 6'h10,
      MODE_IDLE_FAST_ONLY = 6'h20
   } scmc_mode_t;

   // ==========================================================
   // Control fields written by the CPU
   typedef struct packed {
      logic [2:0] sysclk_select;
      logic fast_source_select;
      logic slow_source_select;
      logic halt_fast_osc_keep;
      logic halt_slow_osc_keep;
   } scmc_cfg_t;

   localparam scmc_cfg_t CFG_RESET = '{3'h0, 1'b0, 1'b0, 1'b0, 1'b0};

endpackage : scmc_pkg

// ==== design/scmc_div.sv ====
// Power-of-two divider giving fast clock taps from 1 to 2^(STAGES-1)
`timescale 1ns/1ns
module scmc_div
#(
   parameter int STAGES = 7
)
(
   // Clock and reset
   input wire logic mclk,
   input wire logic rstn,
   // Sampled fast clock level
   input wire logic clk_in,
   // Divided levels, tap k is clk_in divided by 2^k
   output logic [STAGES-1:0] taps
);

   // ==========================================================
   // Elaboration check
   if (STAGES < 2)
   begin : g_bad
      $error("scmc_div needs at least two stages");
   end

   logic prev_q;
   logic [STAGES-2:0] cnt_q;
   logic [STAGES-2:0] cnt_d;
   logic rise;

   // ==========================================================
   // Counter advancing on each rising level of the input
   assign rise = clk_in & ~prev_q;

   always_comb
   begin
      cnt_d = cnt_q;
      if (rise)
      begin
         cnt_d = cnt_q + 1'b1;
      end
   end

   always_ff @(posedge mclk or negedge rstn)
   begin
      if (!rstn)
      begin
         prev_q <= 1'b0;
         cnt_q <= '0;
      end
      else
      begin
         prev_q <= clk_in;
         cnt_q <= cnt_d;
      end
   end

   // ==========================================================
   // Taps: bit k-1 of the counter toggles every 2^(k-1) input edges
   assign taps[0] = clk_in;
   for (genvar k = 1; k < STAGES; k++)
   begin : g_tap
      assign taps[k] = cnt_q[k-1];
   end

   // ==========================================================
   // Half-rate tap only moves on an input rising edge
   a_div_half_rate: assert property (@(posedge mclk) disable iff (!rstn)
      $changed(cnt_q[0]) |-> $past(rise))
      else $error("divide-by-two tap moved without input edge");

endmodule : scmc_div

// ==== design/scmc_ctrl.sv ====
// System clock selection and operating mode controller
//
// Summary of operation
// - Codes 0..6 fast path, 7 sub clock
// - Fast clock from crystal or RC by bit
// - Sub clock from crystal or RC by bit
// - Fast mode divides fast clock 1..64
// - On sub clock, fast oscillator follows enable
// - Two running and four halted modes
// - Halt, no keeps: sleep, clocks stopped
// - Sleep keeps slow RC only with watchdog
// - Halt, slow keep: idle with sub clock
// - Halt, both keeps: everything keeps running
// - Halt, fast keep: idle with fast clock
// - Slow mode: fast clock follows enable bit
// - Decode select as 1,2..64 or sub
// - Fast source: 0 RC, 1 crystal
// - Slow source: 0 RC, 1 crystal
// - Switch after four current system clock periods
`timescale 1ns/1ns
module scmc_ctrl
(
   // Clock and reset
   input wire logic mclk,
   input wire logic rstn,
   // Oscillator levels, asynchronous to mclk
   input wire logic ext_fast_crystal,
   input wire logic int_fast_rc,
   input wire logic ext_slow_crystal,
   input wire logic int_slow_rc,
   // CPU control, same clock
   input wire scmc_pkg::scmc_cfg_t cfg,
   input wire logic fast_osc_enable,
   input wire logic watchdog_timer_enable,
   input wire logic halt_req,
   input wire logic wake_req,
   // Mode and status
   output scmc_pkg::scmc_mode_t mode_q,
   output logic cpu_run_q,
   output logic switch_busy_q,
   // Clocks as levels
   output logic sys_clk_q,
   output logic fast_clock_q,
   output logic sub_clock_q,
   output logic slow_rc_clock_q
);

   // ==========================================================
   // Oscillator synchronisers
   logic [scmc_pkg::OSC_NUM-1:0] osc_pins;
   logic [scmc_pkg::OSC_NUM-1:0] osc_s1_q;
   logic [scmc_pkg::OSC_NUM-1:0] osc_s2_q;

   assign osc_pins[scmc_pkg::OSC_EXT_FAST] = ext_fast_crystal;
   assign osc_pins[scmc_pkg::OSC_INT_FAST] = int_fast_rc;
   assign osc_pins[scmc_pkg::OSC_EXT_SLOW] = ext_slow_crystal;
   assign osc_pins[scmc_pkg::OSC_INT_SLOW] = int_slow_rc;

   // Two stages per pin; only the second stage feeds logic
   for (genvar i = 0; i < scmc_pkg::OSC_NUM; i++)
   begin : g_sync
      always_ff @(posedge mclk or negedge rstn)
      begin
         if (!rstn)
         begin
            osc_s1_q[i] <= 1'b0;
            osc_s2_q[i] <= 1'b0;
         end
         else
         begin
            osc_s1_q[i] <= osc_pins[i];
            osc_s2_q[i] <= osc_s1_q[i];
         end
      end
   end

   // ==========================================================
   // Source selection and clock gating per mode
   logic fast_src;
   logic sub_src;
   logic fast_on;
   logic sub_on;
   logic rc_on;
   logic fast_clock_d;
   logic sub_clock_d;
   logic slow_rc_clock_d;

   assign fast_src = cfg.fast_source_select ?
      osc_s2_q[scmc_pkg::OSC_EXT_FAST] :
      osc_s2_q[scmc_pkg::OSC_INT_FAST];
   assign sub_src = cfg.slow_source_select ?
      osc_s2_q[scmc_pkg::OSC_EXT_SLOW] :
      osc_s2_q[scmc_pkg::OSC_INT_SLOW];

   always_comb
   begin
      fast_on = 1'b0;
      sub_on = 1'b1;
      rc_on = 1'b1;
      unique case (mode_q)
         scmc_pkg::MODE_FAST: fast_on = 1'b1;
         scmc_pkg::MODE_SLOW: fast_on = fast_osc_enable;
         scmc_pkg::MODE_SLEEP:
         begin
            sub_on = 1'b0;
            rc_on = watchdog_timer_enable;
         end
         scmc_pkg::MODE_IDLE_SLOW_ONLY: fast_on = 1'b0;
         scmc_pkg::MODE_IDLE_BOTH: fast_on = 1'b1;
         scmc_pkg::MODE_IDLE_FAST_ONLY:
         begin
            fast_on = 1'b1;
            sub_on = 1'b0;
         end
      endcase
      fast_clock_d = fast_src & fast_on;
      sub_clock_d = sub_src & sub_on;
      slow_rc_clock_d = osc_s2_q[scmc_pkg::OSC_INT_SLOW] & rc_on;
   end

   always_ff @(posedge mclk or negedge rstn)
   begin
      if (!rstn)
      begin
         fast_clock_q <= 1'b0;
         sub_clock_q <= 1'b0;
         slow_rc_clock_q <= 1'b0;
      end
      else
      begin
         fast_clock_q <= fast_clock_d;
         sub_clock_q <= sub_clock_d;
         slow_rc_clock_q <= slow_rc_clock_d;
      end
   end

   // ==========================================================
   // Divided fast clock taps, extended with the sub clock at code 7
   logic [scmc_pkg::DIV_STAGES-1:0] taps;
   logic [scmc_pkg::DIV_STAGES:0] sel_levels;

   scmc_div #(.STAGES(scmc_pkg::DIV_STAGES)) u_div (
      .mclk(mclk),
      .rstn(rstn),
      .clk_in(fast_clock_q),
      .taps(taps)
   );

   assign sel_levels = {sub_clock_q, taps};

   // ==========================================================
   // Glitch-free switch: count current periods, then wait for both
   // levels low so no runt pulse reaches the system clock
   logic [2:0] cur_sel_q;
   logic [2:0] cur_sel_d;
   logic [scmc_pkg::SW_CNT_W-1:0] sw_cnt_q;
   logic [scmc_pkg::SW_CNT_W-1:0] sw_cnt_d;
   logic sys_prev_q;
   logic sys_rise;
   logic pending;
   logic sys_run;
   logic sys_clk_d;
   logic switch_now;

   assign sys_rise = sys_clk_q & ~sys_prev_q;
   assign pending = (cfg.sysclk_select != cur_sel_q);
   assign switch_now = pending
      && (sw_cnt_q == scmc_pkg::SW_CNT_W'(scmc_pkg::SWITCH_PERIODS))
      && !sel_levels[cur_sel_q] && !sel_levels[cfg.sysclk_select];

   always_comb
   begin
      cur_sel_d = cur_sel_q;
      sw_cnt_d = sw_cnt_q;
      if (!pending)
      begin
         sw_cnt_d = '0;
      end
      else if (switch_now)
      begin
         cur_sel_d = cfg.sysclk_select;
         sw_cnt_d = '0;
      end
      else if (sys_rise && sw_cnt_q !=
         scmc_pkg::SW_CNT_W'(scmc_pkg::SWITCH_PERIODS))
      begin
         sw_cnt_d = sw_cnt_q + 1'b1;
      end
   end

   // System clock presence per mode
   always_comb
   begin
      sys_run = 1'b1;
      unique case (mode_q)
         scmc_pkg::MODE_FAST, scmc_pkg::MODE_SLOW,
         scmc_pkg::MODE_IDLE_BOTH: sys_run = 1'b1;
         scmc_pkg::MODE_SLEEP: sys_run = 1'b0;
         scmc_pkg::MODE_IDLE_SLOW_ONLY:
            sys_run = (cur_sel_q == scmc_pkg::SEL_SUB);
         scmc_pkg::MODE_IDLE_FAST_ONLY:
            sys_run = (cur_sel_q != scmc_pkg::SEL_SUB);
      endcase
      sys_clk_d = sys_run & sel_levels[cur_sel_q];
   end

   always_ff @(posedge mclk or negedge rstn)
   begin
      if (!rstn)
      begin
         cur_sel_q <= scmc_pkg::SEL_FAST_DIV1;
         sw_cnt_q <= '0;
         sys_prev_q <= 1'b0;
         sys_clk_q <= 1'b0;
         switch_busy_q <= 1'b0;
      end
      else
      begin
         cur_sel_q <= cur_sel_d;
         sw_cnt_q <= sw_cnt_d;
         sys_prev_q <= sys_clk_q;
         sys_clk_q <= sys_clk_d;
         switch_busy_q <= (cfg.sysclk_select != cur_sel_d);
      end
   end

   // ==========================================================
   // Mode machine: halt picks the idle flavour from the keep bits
   scmc_pkg::scmc_mode_t mode_d;
   scmc_pkg::scmc_mode_t run_mode;

   assign run_mode = (cur_sel_d == scmc_pkg::SEL_SUB) ?
      scmc_pkg::MODE_SLOW : scmc_pkg::MODE_FAST;

   always_comb
   begin
      mode_d = mode_q;
      unique case (mode_q)
         scmc_pkg::MODE_FAST, scmc_pkg::MODE_SLOW:
         begin
            mode_d = run_mode;
            if (halt_req)
            begin
               unique case ({cfg.halt_fast_osc_keep,
                  cfg.halt_slow_osc_keep})
                  2'h0: mode_d = scmc_pkg::MODE_SLEEP;
                  2'h1: mode_d = scmc_pkg::MODE_IDLE_SLOW_ONLY;
                  2'h3: mode_d = scmc_pkg::MODE_IDLE_BOTH;
                  2'h2: mode_d = scmc_pkg::MODE_IDLE_FAST_ONLY;
               endcase
            end
         end
         scmc_pkg::MODE_SLEEP, scmc_pkg::MODE_IDLE_SLOW_ONLY,
         scmc_pkg::MODE_IDLE_BOTH, scmc_pkg::MODE_IDLE_FAST_ONLY:
         begin
            if (wake_req)
            begin
               mode_d = run_mode;
            end
         end
      endcase
   end

   always_ff @(posedge mclk or negedge rstn)
   begin
      if (!rstn)
      begin
         mode_q <= scmc_pkg::MODE_FAST;
         cpu_run_q <= 1'b1;
      end
      else
      begin
         mode_q <= mode_d;
         cpu_run_q <= (mode_d == scmc_pkg::MODE_FAST)
            || (mode_d == scmc_pkg::MODE_SLOW);
      end
   end

   // ==========================================================
   // Checks
   sequence s_halt_plain;
      cpu_run_q && halt_req && !cfg.halt_fast_osc_keep
         && !cfg.halt_slow_osc_keep;
   endsequence

   sequence s_sleep_dark;
      mode_q == scmc_pkg::MODE_SLEEP && !cpu_run_q
         ##1 !sys_clk_q && !fast_clock_q && !sub_clock_q;
   endsequence

   a_halt_to_sleep: assert property (@(posedge mclk) disable iff (!rstn)
      s_halt_plain |=> s_sleep_dark)
      else $error("plain halt did not reach a dark sleep");

   a_run_mode_sel: assert property (@(posedge mclk) disable iff (!rstn)
      (mode_q == scmc_pkg::MODE_SLOW) == (cpu_run_q
         && cur_sel_q == scmc_pkg::SEL_SUB))
      else $error("running mode disagrees with applied selection");

   a_fast_src_pick: assert property (@(posedge mclk) disable iff (!rstn)
      mode_q == scmc_pkg::MODE_FAST && cfg.fast_source_select
         |=> fast_clock_q == $past(osc_s2_q[scmc_pkg::OSC_EXT_FAST]))
      else $error("fast clock not taken from the crystal");

   a_sleep_rc_off: assert property (@(posedge mclk) disable iff (!rstn)
      mode_q == scmc_pkg::MODE_SLEEP && !watchdog_timer_enable
         |=> !slow_rc_clock_q)
      else $error("slow RC clock left running in sleep");

   a_idle_slow_fast: assert property (@(posedge mclk) disable iff (!rstn)
      mode_q == scmc_pkg::MODE_IDLE_SLOW_ONLY
         && cur_sel_q != scmc_pkg::SEL_SUB && $stable(mode_q)
         |=> !sys_clk_q && !fast_clock_q)
      else $error("fast path alive in slow-only idle");

   a_halt_both: assert property (@(posedge mclk) disable iff (!rstn)
      cpu_run_q && halt_req && cfg.halt_fast_osc_keep
         && cfg.halt_slow_osc_keep
         |=> mode_q == scmc_pkg::MODE_IDLE_BOTH && !cpu_run_q)
      else $error("both-keep halt did not enter idle");

   a_idle_fast_sub: assert property (@(posedge mclk) disable iff (!rstn)
      mode_q == scmc_pkg::MODE_IDLE_FAST_ONLY |=> !sub_clock_q)
      else $error("sub clock alive in fast-only idle");

   a_run_keeps_sub: assert property (@(posedge mclk) disable iff (!rstn)
      cpu_run_q |=> sub_clock_q == $past(sub_src))
      else $error("sub clock gated while running");

   a_switch_delay: assert property (@(posedge mclk) disable iff (!rstn)
      $changed(cur_sel_q) |-> $past(sw_cnt_q) ==
         scmc_pkg::SW_CNT_W'(scmc_pkg::SWITCH_PERIODS) && $past(pending))
      else $error("selection switched before four periods");

endmodule : scmc_ctrl

// ==== testbench/scmc_osc_model.sv ====
// Oscillator bank model driving the four source levels
`timescale 1ns/1ns
module scmc_osc_model
#(
   parameter int HALF_EF = 2,
   parameter int HALF_IF = 3,
   parameter int HALF_ES = 10,
   parameter int HALF_IS = 13
)
(
   // Reference clock
   input wire logic mclk,
   // Oscillator levels
   output logic ext_fast_crystal,
   output logic int_fast_rc,
   output logic ext_slow_crystal,
   output logic int_slow_rc
);
   // ==========================================================
   // Free running square waves; distinct rates tell sources apart
   int cnt = 0;
   always @(posedge mclk)
      cnt <= cnt + 1;
   assign ext_fast_crystal = ((cnt / HALF_EF) % 2) == 1;
   assign int_fast_rc = ((cnt / HALF_IF) % 2) == 1;
   assign ext_slow_crystal = ((cnt / HALF_ES) % 2) == 1;
   assign int_slow_rc = ((cnt / HALF_IS) % 2) == 1;
endmodule : scmc_osc_model

// ==== testbench/tb_system_clock_mode_control.sv ====
// Self-checking bench for the system clock and mode controller
`timescale 1ns/1ns
module tb_system_clock_mode_control;
   // ==========================================================
   // Stimulus and observed signals
   logic mclk = 1'b0;
   logic rstn = 1'b0;
   logic efc, ifr, esc, isr;
   scmc_pkg::scmc_cfg_t cfg = scmc_pkg::CFG_RESET;
   logic fast_osc_enable = 1'b0;
   logic watchdog_timer_enable = 1'b0;
   logic halt_req = 1'b0;
   logic wake_req = 1'b0;
   scmc_pkg::scmc_mode_t mode_q;
   logic cpu_run_q, switch_busy_q, sys_clk_q;
   logic fast_clock_q, sub_clock_q, slow_rc_clock_q;
   int n_errors = 0;
   int compares = 0;
   int rises [4]; // 3 sys, 2 fast, 1 sub, 0 slow RC

   // Clock at 100 MHz
   always #5 mclk = ~mclk;

   scmc_osc_model u_osc
   (
      .mclk(mclk),
      .ext_fast_crystal(efc),
      .int_fast_rc(ifr),
      .ext_slow_crystal(esc),
      .int_slow_rc(isr)
   );

   scmc_ctrl u_dut
   (
      .mclk(mclk),
      .rstn(rstn),
      .ext_fast_crystal(efc),
      .int_fast_rc(ifr),
      .ext_slow_crystal(esc),
      .int_slow_rc(isr),
      .cfg(cfg),
      .fast_osc_enable(fast_osc_enable),
      .watchdog_timer_enable(watchdog_timer_enable),
      .halt_req(halt_req),
      .wake_req(wake_req),
      .mode_q(mode_q),
      .cpu_run_q(cpu_run_q),
      .switch_busy_q(switch_busy_q),
      .sys_clk_q(sys_clk_q),
      .fast_clock_q(fast_clock_q),
      .sub_clock_q(sub_clock_q),
      .slow_rc_clock_q(slow_rc_clock_q)
   );

   // ==========================================================
   // Shared helpers
   task automatic check(input logic [7:0] seen, input logic [7:0] exp,
                        input string what);
      compares++;
      if (seen !== exp)
      begin
         n_errors++;
         $display("ERROR %0t %s seen %h expected %h", $time, what, seen,
                  exp);
      end
   endtask : check

   // Rising edges of the four clock outputs over n cycles
   task automatic count(input int n);
      logic [3:0] prev;
      logic [3:0] now;
      prev = 4'hF;
      rises = '{default: 0};
      repeat (n)
      begin
         @(negedge mclk);
         now = {sys_clk_q, fast_clock_q, sub_clock_q, slow_rc_clock_q};
         for (int i = 0; i < 4; i++)
            if (now[i] === 1'b1 && prev[i] === 1'b0)
               rises[i]++;
         prev = now;
      end
   endtask : count

   // Tolerance of one edge covers the unknown phase of each source
   function automatic logic near(input int got, input int exp);
      return got >= exp - 1 && got <= exp + 1;
   endfunction : near

   // Move the selection and wait, bounded, for the switch to land
   task automatic set_sel(input logic [2:0] v);
      int w;
      @(negedge mclk);
      cfg.sysclk_select = v;
      @(negedge mclk);
      check(switch_busy_q, 8'h01, "busy after change");
      w = 0;
      while (switch_busy_q !== 1'b0 && w < 3000)
      begin
         @(negedge mclk);
         w++;
      end
      check(8'(w >= 4), 8'h01, "switch too early");
      check(mode_q, v == 3'h7 ? scmc_pkg::MODE_SLOW : scmc_pkg::MODE_FAST,
            "mode after switch");
   endtask : set_sel

   // ==========================================================
   // Scenarios
   task automatic t_reset;
      @(negedge mclk);
      check({sys_clk_q, fast_clock_q, sub_clock_q}, 8'h00, "rst clocks");
      repeat (2) @(negedge mclk);
      rstn = 1'b1;
      check(mode_q, scmc_pkg::MODE_FAST, "reset mode");
      check({cpu_run_q, switch_busy_q}, 8'h02, "reset run busy");
   endtask : t_reset

   // Every divide ratio from the crystal, then the RC fast source
   task automatic t_divide;
      cfg.fast_source_select = 1'b1;
      for (int k = 0; k < 7; k++)
      begin
         if (k > 0)
            set_sel(3'(k));
         count(1024);
         check(near(rises[3], 256 >> k), 8'h01, "sys rate");
         check(near(rises[2], 256), 8'h01, "fast crystal");
      end
      cfg.fast_source_select = 1'b0;
      count(16);
      count(1024);
      check(near(rises[2], 170), 8'h01, "fast rc");
   endtask : t_divide

   // Sub clock running, both slow sources, fast enable honoured
   task automatic t_slow;
      set_sel(3'h7);
      count(16);
      count(1040);
      check(near(rises[3], 40), 8'h01, "sys on slow rc");
      check(near(rises[1], 40), 8'h01, "sub rc");
      check(near(rises[0], 40), 8'h01, "rc in slow");
      check(8'(rises[2] == 0), 8'h01, "fast off");
      fast_osc_enable = 1'b1;
      cfg.slow_source_select = 1'b1;
      count(16);
      count(1040);
      check(near(rises[1], 52), 8'h01, "sub crystal");
      check(8'(rises[2] > 0), 8'h01, "fast on");
   endtask : t_slow

   // All four halt modes on both selections, watchdog on when slow
   task automatic t_halt;
      scmc_pkg::scmc_mode_t hm [4];
      logic s7;
      hm = '{scmc_pkg::MODE_SLEEP, scmc_pkg::MODE_IDLE_SLOW_ONLY,
             scmc_pkg::MODE_IDLE_FAST_ONLY, scmc_pkg::MODE_IDLE_BOTH};
      for (int s = 0; s < 2; s++)
      begin
         s7 = (s == 0);
         if (!s7)
            set_sel(3'h0);
         for (int k = 0; k < 4; k++)
         begin
            @(negedge mclk);
            {cfg.halt_fast_osc_keep, cfg.halt_slow_osc_keep} = 2'(k);
            watchdog_timer_enable = s7;
            halt_req = 1'b1;
            @(negedge mclk);
            halt_req = 1'b0;
            check(mode_q, hm[k], "halt mode");
            check(cpu_run_q, 8'h00, "cpu stopped");
            count(4);
            count(300);
            check(8'(rises[3] > 0), 8'(k == 3 || (k == 1 && s7) ||
                  (k == 2 && !s7)), "sys gate");
            check(8'(rises[2] > 0), 8'(k > 1), "fast gate");
            check(8'(rises[1] > 0), 8'(k % 2), "sub gate");
            check(8'(rises[0] > 0), 8'(k > 0 || s7), "rc gate");
            wake_req = 1'b1;
            @(negedge mclk);
            wake_req = 1'b0;
            check(mode_q, s7 ? scmc_pkg::MODE_SLOW : scmc_pkg::MODE_FAST,
                  "wake mode");
            check(cpu_run_q, 8'h01, "cpu runs");
         end
      end
   endtask : t_halt

   // ==========================================================
   // Verdict, reached from the main sequence or the watchdog
   task automatic close_out;
      $display("Mismatches %0d, comparisons %0d", n_errors, compares);
      if (n_errors == 0 && compares > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask : close_out

   // Main sequence
   initial
   begin
      t_reset;
      t_divide;
      t_slow;
      t_halt;
      close_out;
   end

   // Watchdog, about two and a half times the expected run
   initial
   begin
      #400000;
      n_errors++;
      $display("ERROR %0t watchdog expired", $time);
      close_out;
   end
endmodule : tb_system_clock_mode_control
